// file: pkg/mfb_pkg.sv
// constants, types and reset values shared by the program and data core
// assumes a single clock domain and an active-low asynchronous reset
package mfb_pkg;

    // program store geometry
    localparam int PAGE_W = 4;
    localparam int PC_W = 6;
    localparam int PAGES = 16;
    localparam int PAGE_WORDS = 64;
    localparam int ROM_WORDS = PAGES * PAGE_WORDS;
    localparam int ROM_AW = PAGE_W + PC_W;
    localparam int INS_W = 8;
    localparam int ROM_BITS = ROM_WORDS * INS_W;

    // data store geometry
    localparam int DW = 4;
    localparam int X_W = 2;
    localparam int FILE_WORDS = 16;
    localparam int RAM_WORDS = 64;
    localparam int RAM_AW = X_W + DW;

    // pin widths
    localparam int K_W = 4;
    localparam int R_COUNT = 13;
    localparam int O_W = 8;
    localparam int OLAT_W = 5;
    localparam int PLA_BITS = (1 << OLAT_W) * O_W;

    // oscillator pulses per instruction cycle
    localparam int CYC_PULSES = 6;

    // start address after reset
    localparam logic [PAGE_W-1:0] START_PAGE = 4'hF;
    localparam logic [PC_W-1:0] START_PC = 6'h00;

    // instruction groups, selected by bits 6..4 when bit 7 is low
    localparam logic [2:0] GRP_MISC = 3'h0;
    localparam logic [2:0] GRP_LDP = 3'h1;
    localparam logic [2:0] GRP_TCY = 3'h2;
    localparam logic [2:0] GRP_YNE = 3'h3;
    localparam logic [2:0] GRP_CMIY = 3'h4;
    localparam logic [2:0] GRP_BIT = 3'h5;
    localparam logic [2:0] GRP_FILE = 3'h6;
    localparam logic [2:0] GRP_ADDC = 3'h7;

    // bit 7 marks a transfer, bit 6 chooses call over branch
    localparam int XFER_BIT = 7;
    localparam int CALL_BIT = 6;

    // register and memory moves, arithmetic and return in the misc group
    localparam logic [3:0] MX_AY = 4'h0;
    localparam logic [3:0] MX_YA = 4'h1;
    localparam logic [3:0] MX_CLA = 4'h2;
    localparam logic [3:0] MX_AM = 4'h3;
    localparam logic [3:0] MX_AMIY = 4'h4;
    localparam logic [3:0] MX_AMZA = 4'h5;
    localparam logic [3:0] MX_MY = 4'h6;
    localparam logic [3:0] MX_MA = 4'h7;
    localparam logic [3:0] MX_XCH = 4'h8;
    localparam logic [3:0] MX_ADDM = 4'h9;
    localparam logic [3:0] MX_SUBM = 4'hA;
    localparam logic [3:0] MX_INCA = 4'hB;
    localparam logic [3:0] MX_DECY = 4'hC;
    localparam logic [3:0] MX_INCY = 4'hD;
    localparam logic [3:0] MX_KA = 4'hE;
    localparam logic [3:0] MX_RET = 4'hF;

    // bit group sub-operations and i/o operations
    localparam logic [1:0] BOP_SET = 2'h0;
    localparam logic [1:0] BOP_CLR = 2'h1;
    localparam logic [1:0] BOP_TST = 2'h2;
    localparam logic [1:0] BOP_IO = 2'h3;
    localparam logic [1:0] IO_SETR = 2'h0;
    localparam logic [1:0] IO_RSTR = 2'h1;
    localparam logic [1:0] IO_LDO = 2'h2;
    localparam logic [1:0] IO_CPX = 2'h3;

    // file group sub-operations
    localparam logic [1:0] FOP_LDX = 2'h0;
    localparam logic [3:0] FOP_KNZ = 4'h4;
    localparam logic [3:0] FOP_DECM = 4'h5;

    // six phases of one instruction cycle
    typedef enum logic [2:0] {
        PH_FETCH, PH_LATCH, PH_READ, PH_ALU, PH_WAIT, PH_COMMIT
    } mfb_phase_t;

    // data store request
    typedef struct packed {
        logic we;
        logic [RAM_AW-1:0] addr;
        logic [DW-1:0] wdata;
    } mfb_ram_req_t;

    // whole state of the core
    typedef struct packed {
        mfb_phase_t ph;
        logic [PC_W-1:0] pc;
        logic [PAGE_W-1:0] pa;
        logic [PAGE_W-1:0] pb;
        logic [PC_W-1:0] ret;
        logic in_call;
        logic st;
        logic [DW-1:0] acc;
        logic [DW-1:0] y;
        logic [X_W-1:0] x;
        logic [INS_W-1:0] ins;
        logic [R_COUNT-1:0] r;
        logic [OLAT_W-1:0] olat;
        logic [O_W-1:0] oout;
        logic [K_W-1:0] k1;
        logic [K_W-1:0] k2;
        logic [K_W-1:0] k3;
        logic [K_W-1:0] kv;
    } mfb_core_t;

    localparam mfb_core_t CORE_RST = '{ph: PH_FETCH, pc: START_PC,
        pa: START_PAGE, pb: START_PAGE, st: 1'h1, default: '0};

    // default decoder passes the five latches straight to the low pins
    function automatic logic [PLA_BITS-1:0] pla_default();
        logic [PLA_BITS-1:0] t;
        t = '0;
        for (int i = 0; i < (1 << OLAT_W); i++) begin
            t[i*O_W +: O_W] = 8'(i);
        end
        return t;
    endfunction

endpackage

// file: rtl/mfb_core.sv
// program sequencing and data addressing core of a four-bit computer
// assumes one clock; k pins are asynchronous and are synchronised here
//
// What this block does
// - holds 1024 eight-bit words as 16 pages of 64, run in shift-register order
// - starts at one fixed page and counter value after reset
// - program counter is a shift register stepping through the page
// - taken branch or call loads the six-bit counter with the target
// - one return address register; no deeper nesting is kept
// - four-bit page register selects one of sixteen pages
// - constant loads page buffer; a taken transfer outside call mode, or a return, copies it over
// - in call mode the page buffer keeps the return page
// - data store of 256 bits as four files of 16 four-bit words
// - word pointer picks one of 16 words, two bits pick the file
// - word pointer compared, loaded, stepped up, down and moved
// - file select changes only by constant load or complement
// - store writes take the accumulator or an instruction constant
// - store data reaches the adder; result to pointer or accumulator
// - any bit of the selected word can be set, cleared or tested
// - thirteen output latches, each set or reset on its own
// - eight outputs decoded by a programmable array from five latches
// - input lines pass through the synchroniser into the accumulator, not the adder
// - accumulator feeds output latches, store writes and the adder
// - every eight-bit code decodes to some operation, except 66 to 6F, which do nothing
// - each instruction takes one cycle of six clock pulses
// - transfers go only when status is one; status resets each cycle
`timescale 1ns/1ns
module mfb_core #(
    parameter logic [mfb_pkg::ROM_BITS-1:0] ROM_IMAGE = '0,
    parameter logic [mfb_pkg::PLA_BITS-1:0] O_PLA =
        mfb_pkg::pla_default()
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic RESET_N,
    // input lines
    input wire logic [mfb_pkg::K_W-1:0] K_IN,
    // individually addressed latches
    output logic [mfb_pkg::R_COUNT-1:0] R_OUT,
    // decoded parallel outputs
    output logic [mfb_pkg::O_W-1:0] O_OUT
);
    import mfb_pkg::*;

    mfb_core_t q;
    mfb_core_t n;
    mfb_ram_req_t ram_req;
    logic [INS_W-1:0] rom_q;
    logic [DW-1:0] ram_q;
    logic [PC_W-1:0] pc_seq;
    logic [DW-1:0] bmask;
    logic [DW:0] y_up;
    logic [DW:0] y_dn;
    logic [DW:0] a_m;
    logic [DW:0] m_a;
    logic [DW:0] a_c;
    logic [DW:0] a_1;
    logic [DW:0] m_1;
    logic commit;
    logic is_ret;
    logic x_op;

    // four-bit adder with carry in, carry out on top
    function automatic logic [DW:0] add4(input logic [DW-1:0] a,
                                         input logic [DW-1:0] b,
                                         input logic ci);
        return {1'h0, a} + {1'h0, b} + {4'h0, ci};
    endfunction

    // six-bit feedback shift; the lock-up value falls back to zero
    function automatic logic [PC_W-1:0] pc_step(input logic [PC_W-1:0] p);
        if (p == 6'h3F) begin
            return 6'h00;
        end
        return {p[PC_W-2:0], ~(p[PC_W-1] ^ p[PC_W-2])};
    endfunction

    // programmable decode of the five output latches
    function automatic logic [O_W-1:0] pla_out(input logic [OLAT_W-1:0] v);
        return O_PLA[{v, 3'h0} +: O_W];
    endfunction

    // program store addressed by page and counter
    mfb_rom #(
        .IMAGE(ROM_IMAGE)
    ) u_rom (
        .clk(MCLK),
        .rst_n(RESET_N),
        .addr({q.pa, q.pc}),
        .data(rom_q)
    );

    // data store addressed by file select and word pointer
    mfb_ram u_ram (
        .clk(MCLK),
        .rst_n(RESET_N),
        .req(ram_req),
        .rdata(ram_q)
    );

    // shared adder results and decode helpers
    assign pc_seq = pc_step(q.pc);
    assign bmask = 4'h1 << q.ins[1:0];
    assign y_up = add4(q.y, 4'h1, 1'h0);
    assign y_dn = add4(q.y, 4'hF, 1'h0);
    assign a_m = add4(ram_q, q.acc, 1'h0);
    assign m_a = add4(ram_q, ~q.acc, 1'h1);
    assign a_c = add4(q.acc, q.ins[3:0], 1'h0);
    assign a_1 = add4(q.acc, 4'h1, 1'h0);
    assign m_1 = add4(ram_q, 4'hF, 1'h0);
    assign commit = (q.ph == PH_COMMIT);
    assign is_ret = (q.ins == {1'h0, GRP_MISC, MX_RET});
    assign x_op = (q.ins[7:4] == {1'h0, GRP_FILE} &&
                   q.ins[3:2] == FOP_LDX) ||
                  (q.ins[7:2] == {1'h0, GRP_BIT, BOP_IO} &&
                   q.ins[1:0] == IO_CPX);

    // next state: pin sync, output decode, phase walk and execution
    always_comb begin
        n = q;
        ram_req = '{we: 1'h0, addr: {q.x, q.y}, wdata: q.acc};
        n.k1 = K_IN;
        n.k2 = q.k1;
        n.k3 = q.k2;
        if (q.k2 == q.k3) begin
            n.kv = q.k3;
        end
        n.oout = pla_out(q.olat);
        unique case (q.ph)
            PH_FETCH: n.ph = PH_LATCH;
            PH_LATCH: n.ph = PH_READ;
            PH_READ: begin
                n.ins = rom_q;
                n.ph = PH_ALU;
            end
            PH_ALU: n.ph = PH_WAIT;
            PH_WAIT: n.ph = PH_COMMIT;
            PH_COMMIT: begin
                n.ph = PH_FETCH;
                n.st = 1'h1;
                n.pc = pc_seq;
                if (q.ins[XFER_BIT]) begin
                    if (q.st) begin
                        n.pc = q.ins[PC_W-1:0];
                        if (!q.in_call) begin
                            n.pa = q.pb;
                            if (q.ins[CALL_BIT]) begin
                                n.pb = q.pa;
                                n.ret = pc_seq;
                                n.in_call = 1'h1;
                            end
                        end
                    end
                end else begin
                    unique case (q.ins[6:4])
                        GRP_MISC: begin
                            unique case (q.ins[3:0])
                                MX_AY: n.y = q.acc;
                                MX_YA: n.acc = q.y;
                                MX_CLA: n.acc = '0;
                                MX_AM: ram_req.we = 1'h1;
                                MX_AMIY: begin
                                    ram_req.we = 1'h1;
                                    n.y = y_up[DW-1:0];
                                end
                                MX_AMZA: begin
                                    ram_req.we = 1'h1;
                                    n.acc = '0;
                                end
                                MX_MY: n.y = ram_q;
                                MX_MA: n.acc = ram_q;
                                MX_XCH: begin
                                    ram_req.we = 1'h1;
                                    n.acc = ram_q;
                                end
                                MX_ADDM: begin
                                    n.acc = a_m[DW-1:0];
                                    n.st = a_m[DW];
                                end
                                MX_SUBM: begin
                                    n.acc = m_a[DW-1:0];
                                    n.st = m_a[DW];
                                end
                                MX_INCA: n.acc = a_1[DW-1:0];
                                MX_DECY: begin
                                    n.y = y_dn[DW-1:0];
                                    n.st = y_dn[DW];
                                end
                                MX_INCY: begin
                                    n.y = y_up[DW-1:0];
                                    n.st = y_up[DW];
                                end
                                MX_KA: n.acc = q.kv;
                                MX_RET: begin
                                    if (q.in_call) begin
                                        n.pc = q.ret;
                                        n.pa = q.pb;
                                        n.in_call = 1'h0;
                                    end
                                end
                            endcase
                        end
                        GRP_LDP: begin
                            if (!q.in_call) begin
                                n.pb = q.ins[3:0];
                            end
                        end
                        GRP_TCY: n.y = q.ins[3:0];
                        GRP_YNE: n.st = (q.y != q.ins[3:0]);
                        GRP_CMIY: begin
                            ram_req.we = 1'h1;
                            ram_req.wdata = q.ins[3:0];
                            n.y = y_up[DW-1:0];
                        end
                        GRP_BIT: begin
                            unique case (q.ins[3:2])
                                BOP_SET: begin
                                    ram_req.we = 1'h1;
                                    ram_req.wdata = ram_q | bmask;
                                end
                                BOP_CLR: begin
                                    ram_req.we = 1'h1;
                                    ram_req.wdata = ram_q & ~bmask;
                                end
                                BOP_TST: n.st = |(ram_q & bmask);
                                BOP_IO: begin
                                    unique case (q.ins[1:0])
                                        IO_SETR: begin
                                            if (q.y < 4'(R_COUNT)) begin
                                                n.r[q.y] = 1'h1;
                                            end
                                        end
                                        IO_RSTR: begin
                                            if (q.y < 4'(R_COUNT)) begin
                                                n.r[q.y] = 1'h0;
                                            end
                                        end
                                        IO_LDO: n.olat = {q.st, q.acc};
                                        IO_CPX: n.x = ~q.x;
                                    endcase
                                end
                            endcase
                        end
                        GRP_FILE: begin
                            if (q.ins[3:2] == FOP_LDX) begin
                                n.x = q.ins[X_W-1:0];
                            end else if (q.ins[3:0] == FOP_KNZ) begin
                                n.st = |q.kv;
                            end else if (q.ins[3:0] == FOP_DECM) begin
                                n.acc = m_1[DW-1:0];
                                n.st = m_1[DW];
                            end
                        end
                        GRP_ADDC: begin
                            n.acc = a_c[DW-1:0];
                            n.st = a_c[DW];
                        end
                    endcase
                end
            end
            default: n.ph = PH_FETCH;
        endcase
    end

    // state register
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            q <= CORE_RST;
        end else begin
            q <= n;
        end
    end

    // outputs straight from the state register
    assign R_OUT = q.r;
    assign O_OUT = q.oout;

    // six pulses from one commit to the next
    property p_cycle;
        @(posedge MCLK) disable iff (!RESET_N)
        commit |=> q.ph == PH_FETCH ##5 q.ph == PH_COMMIT;
    endproperty
    a_cycle: assert property (p_cycle)
        else $error("instruction cycle is not six pulses");

    // transfers leave status at one
    property p_st_back;
        @(posedge MCLK) disable iff (!RESET_N)
        commit && q.ins[XFER_BIT] |=> q.st ##1 q.st [*5];
    endproperty
    a_st_back: assert property (p_st_back)
        else $error("status did not return to one");

    // taken transfer lands on the target
    property p_br_taken;
        @(posedge MCLK) disable iff (!RESET_N)
        commit && q.ins[XFER_BIT] && q.st |=> q.pc == q.ins[PC_W-1:0];
    endproperty
    a_br_taken: assert property (p_br_taken)
        else $error("taken transfer missed its target");

    // refused transfer steps on and keeps the page
    property p_br_skip;
        @(posedge MCLK) disable iff (!RESET_N)
        commit && q.ins[XFER_BIT] && !q.st
            |=> q.pc == $past(pc_seq) && $stable(q.pa);
    endproperty
    a_br_skip: assert property (p_br_skip)
        else $error("transfer taken with status zero");

    // page changes only on a transfer or a return
    property p_pa_only;
        @(posedge MCLK) disable iff (!RESET_N)
        (!commit || (!q.ins[XFER_BIT] && !is_ret)) |=> $stable(q.pa);
    endproperty
    a_pa_only: assert property (p_pa_only)
        else $error("page changed without a transfer");

    // call saves the return counter and page
    property p_call;
        @(posedge MCLK) disable iff (!RESET_N)
        commit && q.ins[7:6] == 2'h3 && q.st && !q.in_call
            |=> q.in_call && q.ret == $past(pc_seq) && q.pb == $past(q.pa);
    endproperty
    a_call: assert property (p_call)
        else $error("call did not save its return");

    // return restores counter and page
    property p_ret;
        @(posedge MCLK) disable iff (!RESET_N)
        commit && is_ret && q.in_call
            |=> !q.in_call && q.pc == $past(q.ret) && q.pa == $past(q.pb);
    endproperty
    a_ret: assert property (p_ret)
        else $error("return did not restore counter and page");

    // file select moves only on its own operations
    property p_x;
        @(posedge MCLK) disable iff (!RESET_N)
        !(commit && x_op) |=> $stable(q.x);
    endproperty
    a_x: assert property (p_x)
        else $error("file select changed unexpectedly");

    // store writes happen only in the last phase
    property p_we;
        @(posedge MCLK) disable iff (!RESET_N)
        ram_req.we |-> commit && ram_req.addr == {q.x, q.y};
    endproperty
    a_we: assert property (p_we)
        else $error("store write outside its slot");

    // constant store write steps the word pointer
    property p_cmiy;
        @(posedge MCLK) disable iff (!RESET_N)
        commit && q.ins[7:4] == {1'h0, GRP_CMIY}
            |-> ram_req.wdata == q.ins[3:0] ##1 q.y == $past(q.y) + 4'h1;
    endproperty
    a_cmiy: assert property (p_cmiy)
        else $error("constant write or pointer step wrong");

    // held input value changes only once two stages agree
    property p_k;
        @(posedge MCLK) disable iff (!RESET_N)
        !$stable(q.kv) |-> $past(q.k2) == $past(q.k3);
    endproperty
    a_k: assert property (p_k)
        else $error("input taken before it settled");

endmodule

// file: rtl/mfb_ram.sv
// data store, 64 words of four bits, one write port, registered read
// assumes a write and a read of the same word return the old word
`timescale 1ns/1ns
module mfb_ram (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // access port
    input wire mfb_pkg::mfb_ram_req_t req,
    output logic [mfb_pkg::DW-1:0] rdata
);
    import mfb_pkg::*;

    logic [DW-1:0] mem [RAM_WORDS];
    logic [DW-1:0] rdata_r;

    // storage array, no reset
    always_ff @(posedge clk) begin
        if (req.we) begin
            mem[req.addr] <= req.wdata;
        end
    end

    // read register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= mem[req.addr];
        end
    end

    assign rdata = rdata_r;
endmodule

// file: rtl/mfb_rom.sv
// mask program store, 1024 words of eight bits, registered read
// assumes the image is fixed at elaboration and the address is steady
`timescale 1ns/1ns
module mfb_rom #(
    parameter logic [mfb_pkg::ROM_BITS-1:0] IMAGE = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // read port
    input wire logic [mfb_pkg::ROM_AW-1:0] addr,
    output logic [mfb_pkg::INS_W-1:0] data
);
    import mfb_pkg::*;

    logic [INS_W-1:0] data_r;
    logic [INS_W-1:0] data_nxt;

    // word select from the packed image
    always_comb begin
        data_nxt = IMAGE[{addr, 3'h0} +: INS_W];
    end

    // read register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_r <= '0;
        end else begin
            data_r <= data_nxt;
        end
    end

    assign data = data_r;
endmodule

// file: verification/mfb_keys.sv
// keyboard model: four key lines read back while strobe latch 0 is high
// assumes key lines have pull-downs, so an unstrobed row reads zero
`timescale 1ns/1ns
module mfb_keys #(
    parameter logic [3:0] KEYS = 4'hA
) (
    // strobes from the core
    input wire logic [12:0] r_out,
    // key lines back to the core
    output logic [3:0] k_in
);
    // pressed keys show only on the strobed row
    assign k_in = r_out[0] ? KEYS : 4'h0;
endmodule

// file: verification/tb_mfb_core.sv
// bench for the program core: runs one fixed program, checks the latches
// assumes the package, the core and the key model are compiled first
`timescale 1ns/1ns
module tb_mfb_core;
    import mfb_pkg::*;
    typedef logic [ROM_BITS-1:0] mfb_img_t;
    // program: page F, branch into page 2, then a call into page 3
    function automatic mfb_img_t mk_img();
        mfb_img_t m;
        m = '0;
        m[10'h3C0*8 +: 8] = 8'h12; // buffer = 2
        m[10'h3C1*8 +: 8] = 8'h23; // y = 3
        m[10'h3C3*8 +: 8] = 8'h5C; // latch 3 on
        m[10'h3C7*8 +: 8] = 8'h85; // branch to 2:05
        m[10'h085*8 +: 8] = 8'h27; // y = 7
        m[10'h08B*8 +: 8] = 8'h5C; // latch 7 on
        m[10'h097*8 +: 8] = 8'h37; // status = (y != 7), zero
        m[10'h0AE*8 +: 8] = 8'h80; // branch, must fall through
        m[10'h09C*8 +: 8] = 8'h2B; // y = 11
        m[10'h0B8*8 +: 8] = 8'h5C; // latch 11 on
        m[10'h0B1*8 +: 8] = 8'h75; // acc += 5, no carry
        m[10'h0A3*8 +: 8] = 8'h5E; // outputs = {status, acc}
        m[10'h086*8 +: 8] = 8'h13; // buffer = 3
        m[10'h08D*8 +: 8] = 8'hC0; // call 3:00, returns to 2:1B
        m[10'h0C0*8 +: 8] = 8'h15; // buffer load ignored in call mode
        m[10'h0C1*8 +: 8] = 8'h61; // file 1
        m[10'h0C3*8 +: 8] = 8'h24; // y = 4
        m[10'h0C7*8 +: 8] = 8'h49; // mem = 9, y = 5
        m[10'h0CF*8 +: 8] = 8'h0C; // y = 4
        m[10'h0DF*8 +: 8] = 8'h51; // set bit 1, mem = B
        m[10'h0FE*8 +: 8] = 8'h57; // clear bit 3, mem = 3
        m[10'h0FD*8 +: 8] = 8'h5F; // file 2
        m[10'h0FB*8 +: 8] = 8'h46; // mem = 6, y = 5
        m[10'h0F7*8 +: 8] = 8'h0C; // y = 4
        m[10'h0EF*8 +: 8] = 8'h5F; // file 1
        m[10'h0DE*8 +: 8] = 8'h07; // acc = mem = 3
        m[10'h0FC*8 +: 8] = 8'h0F; // return
        m[10'h09B*8 +: 8] = 8'h5E; // outputs = {1, 3}
        m[10'h0B6*8 +: 8] = 8'h20; // y = 0
        m[10'h0AD*8 +: 8] = 8'h5C; // latch 0 on, strobes the keys
        m[10'h09A*8 +: 8] = 8'h0E; // acc = keys
        m[10'h0B4*8 +: 8] = 8'h5E; // outputs = {1, keys}
        m[10'h0A9*8 +: 8] = 8'h5D; // latch 0 off
        return m;
    endfunction
    logic mclk;
    logic reset_n;
    logic [K_W-1:0] k_in;
    logic [R_COUNT-1:0] r_out;
    logic [O_W-1:0] o_out;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;
    mfb_core #(.ROM_IMAGE(mk_img())) dut (.MCLK(mclk), .RESET_N(reset_n),
        .K_IN(k_in), .R_OUT(r_out), .O_OUT(o_out));
    mfb_keys keys (.r_out(r_out), .k_in(k_in));
    // clock, 50 ns period
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // hang guard, the program needs about 250 cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 600) begin
            bad_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (bad_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // edges after release, sampled once settled
    task automatic wait_edges(int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic do_reset();
        @(posedge mclk);
        reset_n <= 1'b0;
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
    endtask
    task automatic chk_r(logic [R_COUNT-1:0] e);
        checks++;
        if (r_out !== e) begin
            bad_count++;
            $display("BAD %0t latches %h want %h", $time, r_out, e);
        end
    endtask
    task automatic chk_o(logic [O_W-1:0] e);
        checks++;
        if (o_out !== e) begin
            bad_count++;
            $display("BAD %0t outputs %h want %h", $time, o_out, e);
        end
    endtask
    // third instruction from the start address sets latch 3
    task automatic t_start();
        wait_edges(17);
        chk_r(13'h0000);
        wait_edges(1);
        chk_r(13'h0008);
    endtask
    // taken branch lands on page 2 counter 05
    task automatic t_branch();
        wait_edges(18);
        chk_r(13'h0088);
    endtask
    // branch after a false compare falls through
    task automatic t_status();
        wait_edges(24);
        chk_r(13'h0888);
    endtask
    // load outputs: status 0, acc 5, decoded one edge later
    task automatic t_output();
        wait_edges(12);
        chk_o(8'h00);
        wait_edges(1);
        chk_o(8'h05);
    endtask
    // call into page 3 works the store and returns to page 2
    task automatic t_call();
        wait_edges(95);
        chk_o(8'h05);
        wait_edges(1);
        chk_o(8'h13);
    endtask
    // latch 0 strobes the keys; they reach the outputs through acc
    task automatic t_keys();
        wait_edges(11);
        chk_r(13'h0889);
        wait_edges(13);
        chk_o(8'h1A);
        wait_edges(5);
        chk_r(13'h0888);
    endtask
    // reset in mid-run clears latches and restarts at the fixed address
    task automatic t_rerun();
        @(posedge mclk);
        reset_n <= 1'b0;
        wait_edges(2);
        chk_r(13'h0000);
        chk_o(8'h00);
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        wait_edges(18);
        chk_r(13'h0008);
    endtask
    initial begin
        reset_n = 1'b0;
        do_reset();
        t_start();
        t_branch();
        t_status();
        t_output();
        t_call();
        t_keys();
        t_rerun();
        stop_test();
    end
endmodule
